// File: oag_pkg.sv
// package for the operand address generator: specifier fields, modes, steps
// assumes a 16-bit byte-addressed memory and eight 16-bit general registers
package oag_pkg;
    localparam int OAG_DATA_W = 16;
    localparam int OAG_REG_N = 8;
    localparam logic [2:0] OAG_SP_IDX = 3'h6;
    localparam logic [2:0] OAG_PC_IDX = 3'h7;
    localparam int OAG_BYTE_BIT = 15;
    localparam int OAG_SRC_LSB = 6;
    localparam int OAG_DST_LSB = 0;
    localparam logic [15:0] OAG_STEP_BYTE = 16'h0001;
    localparam logic [15:0] OAG_STEP_WORD = 16'h0002;
    localparam logic [15:0] OAG_REG_RST = 16'h0000;
    localparam logic [2:0] OAG_MODE_REG = 3'h0;
    localparam logic [2:0] OAG_MODE_AINC = 3'h2;
    localparam logic [2:0] OAG_MODE_ADEC = 3'h4;
    localparam logic [2:0] OAG_MODE_IDX = 3'h6;

    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] regsel;
    } oag_spec_s;

    typedef struct packed {
        logic [15:0] value;
        logic [15:0] addr;
        logic in_reg;
    } oag_opnd_s;

    typedef enum logic [7:0] {
        OAG_IDLE = 8'h01,
        OAG_STEP = 8'h02,
        OAG_EXT = 8'h04,
        OAG_PTR = 8'h08,
        OAG_RDOP = 8'h10,
        OAG_DONE = 8'h20,
        OAG_WRITE = 8'h40,
        OAG_WMEM = 8'h80
    } oag_state_e;
endpackage

// File: oag_regfile.sv
// eight general registers with one write port and byte-lane write
// assumes a single writer per cycle from the address generator
`timescale 1ns/10ps
module oag_regfile
    import oag_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic wr_low_only,
    input wire logic [2:0] wr_sel,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH*8-1:0] regs_flat
);
    // byte lane split below is fixed at eight bits of a 16-bit word
    if (WIDTH != 16)
    begin : g_bad_width
        $error("oag_regfile: width must be 16");
    end

    logic [WIDTH-1:0] regs_reg [0:7];

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_reg
            wire hit = wr_en && (wr_sel == 3'(g));
            wire [WIDTH-1:0] reg_next = wr_low_only ?
                {regs_reg[g][WIDTH-1:8], wr_data[7:0]} : wr_data;
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                    regs_reg[g] <= OAG_REG_RST;
                else if (hit)
                    regs_reg[g] <= reg_next;
            end
            assign regs_flat[g*WIDTH +: WIDTH] = regs_reg[g];
        end
    endgenerate
endmodule

// File: oag_decode.sv
// combinational decode of one 6-bit operand specifier
// assumes byte flag comes from bit 15 of the instruction word
`timescale 1ns/10ps
module oag_decode
    import oag_pkg::*;
(
    input wire logic [5:0] spec_bits,
    input wire logic byte_op,
    output oag_spec_s spec,
    output logic deferred,
    output logic needs_ext,
    output logic [15:0] step
);
    // low three bits pick the register, upper three the mode
    // one driver for the whole struct: mode in the upper bits, register below
    assign spec = oag_spec_s'(spec_bits);
    assign deferred = spec_bits[3];
    assign needs_ext = (spec_bits[5:4] == 2'h3);
    // word step for sp, pc and any pointer fetch
    wire wide = !byte_op || deferred || (spec_bits[2:0] == OAG_SP_IDX)
        || (spec_bits[2:0] == OAG_PC_IDX);
    assign step = wide ? OAG_STEP_WORD : OAG_STEP_BYTE;
endmodule

// File: oag_top.sv
// operand address generator: resolves source and destination operands
// assumes a memory port that answers a read with mem_rvalid some cycles later
`timescale 1ns/10ps
module oag_top
    import oag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic two_op,
    input wire logic [15:0] result,
    input wire logic result_valid,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_rvalid,
    output logic mem_req_reg,
    output logic mem_we_reg,
    output logic mem_byte_reg,
    output logic [15:0] mem_addr_reg,
    output logic [15:0] mem_wdata_reg,
    output logic [15:0] src_value_reg,
    output logic [15:0] dst_value_reg,
    output logic operands_ready_reg,
    output logic done_reg,
    output logic busy_reg
);
    // ****************************************
    // decode and register file
    // ****************************************
    oag_state_e state_reg;
    oag_state_e state_next;
    logic phase_reg; // 0 source, or the sole operand of a one-operand op; 1 destination
    logic [15:0] addr_reg;
    logic [15:0] dst_addr_reg;
    logic dst_in_reg_reg;
    logic [127:0] regs_flat;
    oag_spec_s spec;
    logic deferred;
    logic needs_ext;
    logic [15:0] step;
    logic rf_we;
    logic rf_low;
    logic [2:0] rf_sel;
    logic [15:0] rf_data;

    wire byte_op = instr[OAG_BYTE_BIT];
    // source first so its extension word is consumed before the destination's
    wire [5:0] cur_bits = (two_op && !phase_reg) ? instr[OAG_SRC_LSB +: 6]
        : instr[OAG_DST_LSB +: 6];

    oag_decode u_dec (
        .spec_bits(cur_bits),
        .byte_op(byte_op),
        .spec(spec),
        .deferred(deferred),
        .needs_ext(needs_ext),
        .step(step)
    );

    oag_regfile #(.WIDTH(16)) u_rf (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(rf_we),
        .wr_low_only(rf_low),
        .wr_sel(rf_sel),
        .wr_data(rf_data),
        .regs_flat(regs_flat)
    );

    function automatic logic [15:0] reg_of(input logic [127:0] f, input logic [2:0] s);
        reg_of = f[{s, 4'h0} +: 16];
    endfunction

    wire [15:0] sel_val = reg_of(regs_flat, spec.regsel);
    wire [15:0] pc_val = reg_of(regs_flat, OAG_PC_IDX);
    wire [2:0] base_mode = {spec.mode[2:1], 1'b0};
    wire is_reg_mode = (spec.mode == OAG_MODE_REG);
    wire [15:0] dec_val = sel_val - step;
    wire [15:0] inc_val = sel_val + step;
    wire last_phase = !two_op || phase_reg;

    // ****************************************
    // state sequencing
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            OAG_IDLE: if (start) state_next = OAG_STEP;
            OAG_STEP:
            begin
                if (is_reg_mode)
                    state_next = OAG_DONE;
                else if (needs_ext)
                    state_next = OAG_EXT;
                else if (deferred && spec.mode != 3'h1)
                    state_next = OAG_PTR;
                else
                    state_next = OAG_RDOP;
            end
            OAG_EXT: if (mem_rvalid) state_next = deferred ? OAG_PTR : OAG_RDOP;
            OAG_PTR: if (mem_rvalid) state_next = OAG_RDOP;
            OAG_RDOP: if (mem_rvalid) state_next = OAG_DONE;
            OAG_DONE: if (!last_phase) state_next = OAG_STEP;
                      else state_next = OAG_WRITE;
            OAG_WRITE:
            begin
                if (result_valid)
                    state_next = dst_in_reg_reg ? OAG_IDLE : OAG_WMEM;
            end
            OAG_WMEM: state_next = OAG_IDLE;
            default: state_next = OAG_IDLE;
        endcase
    end

    // register writes: auto steps, pc advance, result into a register
    always_comb
    begin
        rf_we = 1'b0;
        rf_low = 1'b0;
        rf_sel = spec.regsel;
        rf_data = 16'h0000;
        if (state_reg == OAG_STEP && base_mode == OAG_MODE_AINC)
        begin
            rf_we = 1'b1;
            rf_data = inc_val;
        end
        else if (state_reg == OAG_STEP && base_mode == OAG_MODE_ADEC)
        begin
            rf_we = 1'b1;
            rf_data = dec_val;
        end
        else if (state_reg == OAG_EXT && mem_rvalid)
        begin
            rf_we = 1'b1;
            rf_sel = OAG_PC_IDX;
            rf_data = pc_val + OAG_STEP_WORD;
        end
        else if (state_reg == OAG_WRITE && result_valid && dst_in_reg_reg)
        begin
            rf_we = 1'b1;
            rf_low = byte_op;
            rf_sel = instr[2:0];
            rf_data = result;
        end
    end

    // first address of the operand chain
    wire [15:0] first_addr = (base_mode == OAG_MODE_ADEC) ? dec_val : sel_val;
    // index base: pc already past the extension word
    wire [15:0] idx_base = (spec.regsel == OAG_PC_IDX) ? pc_val + OAG_STEP_WORD
        : sel_val;

    // ****************************************
    // datapath and memory port
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_reg <= OAG_IDLE;
            phase_reg <= 1'b0;
            addr_reg <= 16'h0000;
            dst_addr_reg <= 16'h0000;
            dst_in_reg_reg <= 1'b0;
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            mem_byte_reg <= 1'b0;
            mem_addr_reg <= 16'h0000;
            mem_wdata_reg <= 16'h0000;
            src_value_reg <= 16'h0000;
            dst_value_reg <= 16'h0000;
            operands_ready_reg <= 1'b0;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            operands_ready_reg <= 1'b0;
            done_reg <= 1'b0;
            busy_reg <= (state_next != OAG_IDLE);
            if (state_reg == OAG_IDLE)
                phase_reg <= 1'b0;
            if (state_reg == OAG_STEP)
            begin
                if (is_reg_mode)
                begin
                    // operand straight from register, byte op sees low byte
                    if (phase_reg || !two_op)
                        dst_value_reg <= byte_op ? {8'h00, sel_val[7:0]} : sel_val;
                    else
                        src_value_reg <= byte_op ? {8'h00, sel_val[7:0]} : sel_val;
                end
                else
                begin
                    mem_req_reg <= 1'b1;
                    mem_byte_reg <= 1'b0;
                    // index modes read the word at pc, the next instruction word
                    mem_addr_reg <= needs_ext ? pc_val : first_addr;
                    mem_byte_reg <= !needs_ext && !(deferred && spec.mode != 3'h1)
                        && byte_op && (spec.regsel != OAG_PC_IDX);
                end
            end
            if (state_reg == OAG_EXT && mem_rvalid)
            begin
                // sum only, register left as it was
                mem_req_reg <= 1'b1;
                mem_addr_reg <= mem_rdata + idx_base;
                mem_byte_reg <= !deferred && byte_op;
                addr_reg <= mem_rdata + idx_base;
            end
            if (state_reg == OAG_PTR && mem_rvalid)
            begin
                // word read is the operand address
                mem_req_reg <= 1'b1;
                mem_addr_reg <= mem_rdata;
                mem_byte_reg <= byte_op;
                addr_reg <= mem_rdata;
            end
            if (state_reg == OAG_STEP && !is_reg_mode && !needs_ext)
                addr_reg <= first_addr;
            if (state_reg == OAG_RDOP && mem_rvalid)
            begin
                if (last_phase)
                    dst_value_reg <= byte_op ? {8'h00, mem_rdata[7:0]} : mem_rdata;
                else
                    src_value_reg <= byte_op ? {8'h00, mem_rdata[7:0]} : mem_rdata;
            end
            if (state_reg == OAG_DONE)
            begin
                phase_reg <= 1'b1;
                if (last_phase)
                begin
                    operands_ready_reg <= 1'b1;
                    dst_in_reg_reg <= is_reg_mode;
                    dst_addr_reg <= addr_reg;
                end
            end
            if (state_reg == OAG_WRITE && result_valid && !dst_in_reg_reg)
            begin
                // result only to destination location
                mem_req_reg <= 1'b1;
                mem_we_reg <= 1'b1;
                mem_byte_reg <= byte_op;
                mem_addr_reg <= dst_addr_reg;
                mem_wdata_reg <= result;
            end
            if (state_reg == OAG_WMEM || (state_reg == OAG_WRITE && result_valid
                && dst_in_reg_reg))
                done_reg <= 1'b1;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    pc_ext_step_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == OAG_EXT && mem_rvalid) |=> (reg_of(regs_flat, OAG_PC_IDX)
        == $past(pc_val) + 16'h0002))
        else $error("pc not advanced by two after extension fetch");
    ext_from_pc_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == OAG_STEP && needs_ext && !is_reg_mode) |=>
        (mem_req_reg && mem_addr_reg == $past(pc_val)))
        else $error("extension word not read at pc");
    ainc_step_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == OAG_STEP && spec.mode == OAG_MODE_AINC) |=>
        (mem_addr_reg == $past(sel_val)))
        else $error("autoincrement used wrong address");
    adec_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == OAG_STEP && spec.mode == OAG_MODE_ADEC) |=>
        (mem_addr_reg == $past(sel_val) - $past(step)))
        else $error("autodecrement address not predecremented");
    sp_even_step_a: assert property (@(posedge clk_sys) disable iff (reset)
        (spec.regsel == OAG_SP_IDX) |-> (step == 16'h0002))
        else $error("stack pointer step not two");
    defer_step_a: assert property (@(posedge clk_sys) disable iff (reset)
        (deferred && spec.mode[2:1] != 2'h0) |-> (step == 16'h0002))
        else $error("deferred step not two");
    reg_mode_nomem_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == OAG_STEP && is_reg_mode) |=> !mem_req_reg)
        else $error("register mode touched memory");
    ptr_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == OAG_PTR && mem_rvalid) |=> (mem_addr_reg == $past(mem_rdata)))
        else $error("pointer not used as operand address");
    src_first_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == OAG_STEP && two_op && !phase_reg) |->
        (cur_bits == instr[11:6]))
        else $error("destination decoded before source");
    wire [15:0] rf_old = reg_of(regs_flat, rf_sel);
    byte_reg_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (rf_we && rf_low) |=> (reg_of(regs_flat, $past(rf_sel)) ==
        {$past(rf_old[15:8]), $past(rf_data[7:0])}))
        else $error("byte write changed upper byte");
endmodule

// File: oag_mem_model.sv
// memory model behind the operand address generator: words keyed by address
// assumes one outstanding read and a request pulse held for one cycle
`timescale 1ns/10ps
module oag_mem_model
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_byte,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_rvalid
);
    logic [15:0] mem [logic [15:0]];
    logic [32:0] log_q [$];
    logic [15:0] pend_addr;
    logic pend_byte;
    logic [15:0] wv;
    int lat = 1;
    int cnt = 0;

    function automatic logic [15:0] rd(input logic [15:0] a, input logic b);
        logic [15:0] w;
        w = mem.exists({a[15:1], 1'b0}) ? mem[{a[15:1], 1'b0}] : ~a;
        if (b)
        begin
            w = a[0] ? {w[7:0], w[15:8]} : w;
            w[15:8] = ~w[7:0];  // upper lane is junk on a byte read
        end
        return w;
    endfunction

    initial
    begin
        mem_rdata = 16'h0000;
        mem_rvalid = 1'b0;
    end

    // ****
    // answer and log
    // ****
    always @(posedge clk_sys)
    begin
        mem_rvalid <= 1'b0;
        mem_rdata <= ~mem_rdata;  // no answer due: data keeps moving
        if (cnt == 1)
        begin
            mem_rvalid <= 1'b1;
            mem_rdata <= rd(pend_addr, pend_byte);
        end
        if (cnt > 0)
            cnt <= cnt - 1;
        if (!reset && mem_req)
        begin
            log_q.push_back({mem_we, mem_addr, mem_we ? (mem_byte ?
                {8'h00, mem_wdata[7:0]} : mem_wdata) : 16'h0000});
            wv = rd({mem_addr[15:1], 1'b0}, 1'b0);
            if (mem_we && !mem_byte)
                wv = mem_wdata;
            else if (mem_we && mem_addr[0])
                wv[15:8] = mem_wdata[7:0];
            else if (mem_we)
                wv[7:0] = mem_wdata[7:0];
            if (mem_we)
                mem[{mem_addr[15:1], 1'b0}] = wv;
            else
            begin
                pend_addr <= mem_addr;
                pend_byte <= mem_byte;
                cnt <= lat;
            end
        end
        if (reset)
            cnt <= 0;
    end
endmodule

// File: test_oag_top.sv
// self-checking bench for the operand address generator
// assumes registers reset to zero and a memory model on the far side
`timescale 1ns/10ps
module test_oag_top;
    import oag_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic two_op = 1'b0;
    logic [15:0] result = 16'h0000;
    logic result_valid = 1'b0;
    logic [15:0] mem_rdata, mem_addr_reg, mem_wdata_reg, src_value_reg, dst_value_reg;
    logic mem_rvalid, mem_req_reg, mem_we_reg, mem_byte_reg;
    logic operands_ready_reg, done_reg, busy_reg;
    logic [15:0] pc_exp = 16'h0000;
    logic [15:0] srcv, dstv, a;
    logic [32:0] exp_q [$];
    int num_errors = 0;
    int check_count = 0;

    always #12.5 clk_sys = ~clk_sys;

    oag_top i_oag_top (.clk_sys(clk_sys), .reset(reset), .start(start), .instr(instr),
        .two_op(two_op), .result(result), .result_valid(result_valid),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .mem_req_reg(mem_req_reg),
        .mem_we_reg(mem_we_reg), .mem_byte_reg(mem_byte_reg), .mem_addr_reg(mem_addr_reg),
        .mem_wdata_reg(mem_wdata_reg), .src_value_reg(src_value_reg),
        .dst_value_reg(dst_value_reg), .operands_ready_reg(operands_ready_reg),
        .done_reg(done_reg), .busy_reg(busy_reg));

    oag_mem_model i_oag_mem_model (.clk_sys(clk_sys), .reset(reset), .mem_req(mem_req_reg),
        .mem_we(mem_we_reg), .mem_byte(mem_byte_reg), .mem_addr(mem_addr_reg),
        .mem_wdata(mem_wdata_reg), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

    // ****
    // shared tasks
    // ****
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [15:0] i1(input logic b, input logic [2:0] m, input logic [2:0] r);
        return {b, 9'h028, m, r};
    endfunction

    function automatic logic [15:0] i2(input logic b, input logic [5:0] s, input logic [5:0] d);
        return {b, 3'h1, s, d};
    endfunction

    task automatic put(input logic [15:0] adr, input logic [15:0] v);
        i_oag_mem_model.mem[adr] = v;
    endtask

    task automatic ex(input logic w, input logic [15:0] adr, input logic [15:0] d);
        exp_q.push_back({w, adr, d});
    endtask

    // extension word lives at the tracked pc, which then moves on a word
    task automatic ext(input logic [15:0] v);
        put(pc_exp, v);
        ex(1'b0, pc_exp, 16'h0000);
        pc_exp = pc_exp + 16'h0002;
    endtask

    // one whole operation, then the memory trace is compared entry by entry
    task automatic go(input logic [15:0] ins, input logic two, input logic [15:0] res);
        int n;
        i_oag_mem_model.log_q.delete();
        @(negedge clk_sys);
        start = 1'b1;
        instr = ins;
        two_op = two;
        result = res;
        @(negedge clk_sys);
        start = 1'b0;
        for (n = 0; n < 200 && operands_ready_reg !== 1'b1; n++)
            @(negedge clk_sys);
        chk(33'({operands_ready_reg, busy_reg}), 33'h3);
        srcv = src_value_reg;
        dstv = dst_value_reg;
        result_valid = 1'b1;
        for (n = 0; n < 200 && done_reg !== 1'b1; n++)
            @(negedge clk_sys);
        chk(33'({done_reg, busy_reg}), 33'h2);
        result_valid = 1'b0;
        chk(33'(i_oag_mem_model.log_q.size()), 33'(exp_q.size()));
        foreach (exp_q[k])
            if (k < i_oag_mem_model.log_q.size())
                chk(i_oag_mem_model.log_q[k], exp_q[k]);
        exp_q.delete();
    endtask

    task automatic setr(input logic [2:0] r, input logic [15:0] v);
        go(i1(1'b0, 3'h0, r), 1'b0, v);
    endtask

    task automatic peek(input logic [2:0] r, input logic [15:0] v);
        go(i1(1'b0, 3'h0, r), 1'b0, v);
        chk(dstv, v);
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_regs;
        setr(3'h1, 16'h1234);
        peek(3'h1, 16'h1234);
        go(i1(1'b1, 3'h0, 3'h1), 1'b0, 16'hffab);
        chk(dstv, 16'h0034);
        peek(3'h1, 16'h12ab);
        $display("test regs done");
    endtask

    task automatic t_auto;
        setr(3'h2, 16'h0100);
        put(16'h0100, 16'ha1a1);
        ex(1'b0, 16'h0100, 16'h0000);
        ex(1'b1, 16'h0100, 16'h5151);
        go(i1(1'b0, 3'h2, 3'h2), 1'b0, 16'h5151);
        chk(dstv, 16'ha1a1);
        peek(3'h2, 16'h0102);
        put(16'h0102, 16'h3c4d);
        ex(1'b0, 16'h0102, 16'h0000);
        ex(1'b1, 16'h0102, 16'h0099);
        go(i1(1'b1, 3'h2, 3'h2), 1'b0, 16'h0099);
        chk(dstv, 16'h004d);
        peek(3'h2, 16'h0103);
        setr(3'h6, 16'h0200);
        ex(1'b0, 16'h0200, 16'h0000);
        ex(1'b1, 16'h0200, 16'h00aa);
        go(i1(1'b1, 3'h2, 3'h6), 1'b0, 16'h00aa);
        peek(3'h6, 16'h0202);
        ex(1'b0, 16'h0200, 16'h0000);
        ex(1'b1, 16'h0200, 16'h00bb);
        go(i1(1'b1, 3'h4, 3'h6), 1'b0, 16'h00bb);
        peek(3'h6, 16'h0200);
        setr(3'h3, 16'h0300);
        ex(1'b0, 16'h02fe, 16'h0000);
        ex(1'b1, 16'h02fe, 16'h1111);
        go(i1(1'b0, 3'h4, 3'h3), 1'b0, 16'h1111);
        peek(3'h3, 16'h02fe);
        ex(1'b0, 16'h02fd, 16'h0000);
        ex(1'b1, 16'h02fd, 16'h0011);
        go(i1(1'b1, 3'h4, 3'h3), 1'b0, 16'h0011);
        peek(3'h3, 16'h02fd);
        put(16'h0200, 16'h2468);
        ex(1'b0, 16'h0200, 16'h0000);
        ex(1'b1, 16'h0200, 16'h1357);
        go(i1(1'b0, 3'h1, 3'h6), 1'b0, 16'h1357);
        chk(dstv, 16'h2468);
        peek(3'h6, 16'h0200);
        $display("test auto done");
    endtask

    task automatic t_index;
        setr(3'h4, 16'h1000);
        put(16'h1020, 16'h7788);
        ext(16'h0020);
        ex(1'b0, 16'h1020, 16'h0000);
        ex(1'b1, 16'h1020, 16'h0102);
        go(i1(1'b0, 3'h6, 3'h4), 1'b0, 16'h0102);
        chk(dstv, 16'h7788);
        peek(3'h4, 16'h1000);
        put(16'h1020, 16'h7788);
        ext(16'h0021);
        ex(1'b0, 16'h1021, 16'h0000);
        ex(1'b1, 16'h1021, 16'h0055);
        go(i1(1'b1, 3'h6, 3'h4), 1'b0, 16'h0055);
        chk(dstv, 16'h0077);
        peek(3'h7, pc_exp);
        setr(3'h2, 16'h0500);
        put(16'h0500, 16'h0600);
        put(16'h0600, 16'h4242);
        ex(1'b0, 16'h0500, 16'h0000);
        ex(1'b0, 16'h0600, 16'h0000);
        ex(1'b1, 16'h0600, 16'h0066);
        go(i1(1'b1, 3'h3, 3'h2), 1'b0, 16'h0066);
        chk(dstv, 16'h0042);
        peek(3'h2, 16'h0502);
        ex(1'b0, 16'h0500, 16'h0000);
        ex(1'b0, 16'h0600, 16'h0000);
        ex(1'b1, 16'h0600, 16'h0067);
        go(i1(1'b1, 3'h5, 3'h2), 1'b0, 16'h0067);
        peek(3'h2, 16'h0500);
        put(16'h0600, 16'h0700);
        put(16'h0700, 16'h3333);
        ext(16'h0100);
        ex(1'b0, 16'h0600, 16'h0000);
        ex(1'b0, 16'h0700, 16'h0000);
        ex(1'b1, 16'h0700, 16'h4444);
        go(i1(1'b0, 3'h7, 3'h2), 1'b0, 16'h4444);
        chk(dstv, 16'h3333);
        peek(3'h2, 16'h0500);
        $display("test index done");
    endtask

    task automatic t_pc;
        ext(16'h00aa);
        go(i2(1'b0, 6'h17, 6'h00), 1'b1, 16'h00ab);
        chk(srcv, 16'h00aa);
        ext(16'h11bb);
        go(i2(1'b1, 6'h17, 6'h00), 1'b1, 16'h0001);
        chk(srcv, 16'h00bb);
        peek(3'h7, pc_exp);
        put(16'h0800, 16'h4444);
        ext(16'h0800);
        ex(1'b0, 16'h0800, 16'h0000);
        ex(1'b1, 16'h0800, 16'h4545);
        go(i1(1'b0, 3'h3, 3'h7), 1'b0, 16'h4545);
        chk(dstv, 16'h4444);
        a = pc_exp + 16'h0042;
        put(a, 16'h5656);
        ext(16'h0040);
        ex(1'b0, a, 16'h0000);
        ex(1'b1, a, 16'h0001);
        go(i1(1'b0, 3'h6, 3'h7), 1'b0, 16'h0001);
        chk(dstv, 16'h5656);
        a = pc_exp + 16'h0082;
        put(a, 16'h0900);
        put(16'h0900, 16'h6767);
        ext(16'h0080);
        ex(1'b0, a, 16'h0000);
        ex(1'b0, 16'h0900, 16'h0000);
        ex(1'b1, 16'h0900, 16'h0002);
        go(i1(1'b0, 3'h7, 3'h7), 1'b0, 16'h0002);
        chk(dstv, 16'h6767);
        peek(3'h7, pc_exp);
        $display("test pc done");
    endtask

    // slow memory here so the source must be complete before the destination
    task automatic t_two;
        setr(3'h5, 16'h0400);
        i_oag_mem_model.lat = 4;
        put(16'h1002, 16'h1212);
        put(16'h0404, 16'h3434);
        ext(16'h0002);
        ex(1'b0, 16'h1002, 16'h0000);
        ext(16'h0004);
        ex(1'b0, 16'h0404, 16'h0000);
        ex(1'b1, 16'h0404, 16'h9898);
        go(i2(1'b0, 6'h34, 6'h35), 1'b1, 16'h9898);
        chk(srcv, 16'h1212);
        chk(dstv, 16'h3434);
        chk(i_oag_mem_model.mem[16'h1002], 16'h1212);
        i_oag_mem_model.lat = 1;
        $display("test two done");
    endtask

    // ****
    // run
    // ****
    initial
    begin
        #125000;
        num_errors++;
        $display("ERROR %0t watchdog ran out", $time);
        close_out();
    end

    initial
    begin
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        t_regs();
        t_auto();
        t_index();
        t_pc();
        t_two();
        close_out();
    end
endmodule
